// *** src/msr_pkg.sv ***
// Purpose: shared constants for the motor speed reference selector
// Assumes: 25 MHz clock, speeds in rpm, analog levels in 0.01 V / 0.01 mA
// Notes: duty is in per-mille
package msr_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RAMP_TICK_NS = 1000000;
    localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUTTON_TICK_NS = 10000000;
    localparam int BUTTON_TICK_CYC = (BUTTON_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DUTY_TIMEOUT_NS = 25000000;
    localparam int DUTY_TIMEOUT_CYC = DUTY_TIMEOUT_NS / CLK_PERIOD_NS;

    // speeds
    localparam int SPEED_W = 12;
    localparam logic [11:0] RATED_RPM_DEF = 12'h5DC;
    localparam logic [11:0] MIN_RPM_LOW = 12'h0C8;
    localparam logic [11:0] MIN_RPM_HIGH = 12'h1F4;
    localparam logic [11:0] RATED_3000 = 12'hBB8;
    localparam logic [11:0] BUTTON_STEP = 12'h00A;

    // reference ranges: low end, span, top
    localparam logic [11:0] VOLT_LO = 12'h0C8;
    localparam logic [11:0] VOLT_SPAN = 12'h320;
    localparam logic [11:0] VOLT_HI = 12'h3E8;
    localparam logic [11:0] CURR_LO = 12'h190;
    localparam logic [11:0] CURR_SPAN = 12'h640;
    localparam logic [11:0] CURR_HI = 12'h7D0;
    localparam logic [11:0] DUTY_LO = 12'h064;
    localparam logic [11:0] DUTY_SPAN = 12'h352;
    localparam logic [11:0] DUTY_HI = 12'h3B6;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MAXSPD = 8'h04;
    localparam logic [7:0] REG_MINSPD = 8'h08;
    localparam logic [7:0] REG_SERREF = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_DUTY = 8'h14;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // reference sources
    typedef enum logic [1:0] {
        MSR_SRC_PWM = 2'h0,
        MSR_SRC_VOLT = 2'h1,
        MSR_SRC_CURR = 2'h2,
        MSR_SRC_SERIAL = 2'h3
    } msr_src_t;

    // reversal sequence, gray coded
    typedef enum logic [1:0] {
        MSR_RUN = 2'h0,
        MSR_DECEL = 2'h1,
        MSR_FLIP = 2'h3,
        MSR_ACCEL = 2'h2
    } msr_state_t;
endpackage

// *** src/msr_duty_meter.sv ***
// Purpose: measures duty cycle of the pulse-width reference in per-mille
// Assumes: input already synchronised to clock
// Notes: reports zero duty when edges stop arriving
module msr_duty_meter
    import msr_pkg::*;
#(
    parameter int CNT_W = 20,
    parameter int TIMEOUT_CYC = DUTY_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pwmIn,
    output logic [11:0] duty_q,
    output logic dutyValid_q
);
    logic pwmLast_q;
    logic [CNT_W-1:0] highCnt_q;
    logic [CNT_W-1:0] periodCnt_q;
    logic riseEdge;
    logic [CNT_W+9:0] scaled;
    logic [CNT_W+9:0] ratio;

    assign riseEdge = pwmIn && !pwmLast_q;
    assign scaled = {10'h000, highCnt_q} * (CNT_W + 10)'(1000);
    assign ratio = (periodCnt_q == '0) ? '0 : scaled / {10'h000, periodCnt_q};

    // count high time and full period between rising edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwmLast_q <= 1'b0;
            highCnt_q <= '0;
            periodCnt_q <= '0;
        end else begin
            pwmLast_q <= pwmIn;
            if (riseEdge) begin
                highCnt_q <= (CNT_W)'(1);
                periodCnt_q <= (CNT_W)'(1);
            end else if (periodCnt_q != {CNT_W{1'b1}}) begin
                periodCnt_q <= periodCnt_q + (CNT_W)'(1);
                if (pwmIn) begin
                    highCnt_q <= highCnt_q + (CNT_W)'(1);
                end
            end
        end
    end

    // update duty once per period, drop it on timeout
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            duty_q <= 12'h000;
            dutyValid_q <= 1'b0;
        end else if (riseEdge && periodCnt_q != '0) begin
            duty_q <= ratio[11:0];
            dutyValid_q <= 1'b1;
        end else if (32'(periodCnt_q) >= TIMEOUT_CYC) begin
            duty_q <= 12'h000;
            dutyValid_q <= 1'b0;
        end
    end

    chk_duty_update: assert property (@(posedge clock) disable iff (rst)
        !riseEdge && 32'(periodCnt_q) < TIMEOUT_CYC |=> $stable(duty_q))
        else $error("duty changed without a period edge");
endmodule

// *** src/msr_speed_ref.sv ***
// Purpose: speed reference selection, scaling, ramp and direction control
// Assumes: analog level comes from an adc on this clock; pins are asynchronous
// Notes: APB slave with no wait states; nv storage is external
module msr_speed_ref
    import msr_pkg::*;
#(
    parameter logic [11:0] RATED_RPM = RATED_RPM_DEF,
    parameter int RAMP_CYC = RAMP_TICK_CYC,
    parameter int BUTTON_CYC = BUTTON_TICK_CYC,
    parameter int TIMEOUT_CYC = DUTY_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dirSwitchIn,
    input wire logic localSelIn,
    input wire logic direction_select_input,
    input wire logic pulse_width_reference_input,
    input wire logic buttonUpIn,
    input wire logic buttonDownIn,
    input wire logic [11:0] reference_input_level,
    input wire logic [11:0] nvSpeedIn,
    output logic [11:0] nvSpeedOut,
    output logic nvWrite,
    output logic [11:0] speedCmd,
    output logic dirCcw,
    output logic motorOn
);
    localparam logic [11:0] MIN_DEF = (RATED_RPM >= RATED_3000) ? MIN_RPM_HIGH : MIN_RPM_LOW;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [5:0] pinRaw;
    logic [5:0] pinMeta_q;
    logic [5:0] pinSync_q;
    assign pinRaw = {dirSwitchIn, localSelIn, direction_select_input,
                     pulse_width_reference_input, buttonUpIn, buttonDownIn};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : gSync
            // two flops per pin
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    pinMeta_q[gi] <= 1'b0;
                    pinSync_q[gi] <= 1'b0;
                end else begin
                    pinMeta_q[gi] <= pinRaw[gi];
                    pinSync_q[gi] <= pinMeta_q[gi];
                end
            end
        end
    endgenerate
    logic swDir, swLocal, diDir, diPwm, btnUp, btnDown;
    assign {swDir, swLocal, diDir, diPwm, btnUp, btnDown} = pinSync_q;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic frameLarge_q;
    msr_src_t refSel_q;
    logic [11:0] maxSpd_q, minSpd_q, serRef_q;
    logic [11:0] duty, speedNow_q, localSpeed_q;
    logic dutyValid;
    msr_state_t state_q;
    logic localMode;
    logic apbSetup, apbWrite;
    logic [31:0] readMux;
    logic mapped;

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready && pwrite && !pslverr;
    assign mapped = paddr inside {REG_CTRL, REG_MAXSPD, REG_MINSPD, REG_SERREF, REG_STATUS, REG_DUTY};

    // read data selection
    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            REG_CTRL: readMux = {29'h0, refSel_q, frameLarge_q};
            REG_MAXSPD: readMux = {20'h0, maxSpd_q};
            REG_MINSPD: readMux = {20'h0, minSpd_q};
            REG_SERREF: readMux = {20'h0, serRef_q};
            REG_STATUS: readMux = {7'h0, localMode, 2'h0, state_q, 2'h0, motorOn, dirCcw, 4'h0, speedNow_q};
            REG_DUTY: readMux = {19'h0, dutyValid, duty};
            default: readMux = 32'h0000_0000;
        endcase
    end

    // apb answer: ready in the cycle after setup
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbSetup;
            if (apbSetup) begin
                pslverr <= !mapped || (pwrite && paddr inside {REG_STATUS, REG_DUTY});
                prdata <= pwrite ? 32'h0000_0000 : readMux;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // writable configuration
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frameLarge_q <= CTRL_RESET[0];
            refSel_q <= msr_src_t'(CTRL_RESET[2:1]);
            maxSpd_q <= RATED_RPM;
            minSpd_q <= MIN_DEF;
            serRef_q <= 12'h000;
        end else if (apbWrite) begin
            case (paddr)
                REG_CTRL: begin
                    frameLarge_q <= pwdata[0];
                    refSel_q <= msr_src_t'(pwdata[2:1]);
                end
                REG_MAXSPD: maxSpd_q <= (pwdata[11:0] > RATED_RPM) ? RATED_RPM : pwdata[11:0];
                REG_MINSPD: minSpd_q <= pwdata[11:0];
                REG_SERREF: serRef_q <= pwdata[11:0];
                default: serRef_q <= serRef_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tick dividers
    logic [31:0] rampCnt_q, btnCnt_q;
    logic rampTick, btnTick;
    assign rampTick = (rampCnt_q == 32'(RAMP_CYC - 1));
    assign btnTick = (btnCnt_q == 32'(BUTTON_CYC - 1));
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rampCnt_q <= 32'h0;
            btnCnt_q <= 32'h0;
        end else begin
            rampCnt_q <= rampTick ? 32'h0 : rampCnt_q + 32'h1;
            btnCnt_q <= btnTick ? 32'h0 : btnCnt_q + 32'h1;
        end
    end

    msr_duty_meter #(
        .CNT_W(20),
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) uDuty (
        .clock(clock),
        .rst(rst),
        .pwmIn(diPwm),
        .duty_q(duty),
        .dutyValid_q(dutyValid)
    );

    ////////////////////////////////////////////////////////////////////////
    // local button speed and nv storage
    logic nvLoaded_q;
    logic [11:0] nvClamped;
    assign localMode = !frameLarge_q && swLocal;
    assign nvClamped = (nvSpeedIn > maxSpd_q) ? maxSpd_q : nvSpeedIn;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nvLoaded_q <= 1'b0;
            localSpeed_q <= 12'h000;
        end else if (!nvLoaded_q) begin
            nvLoaded_q <= 1'b1;
            localSpeed_q <= nvClamped;
        end else if (localSpeed_q > maxSpd_q) begin
            localSpeed_q <= maxSpd_q;
        end else if (localMode && btnTick && btnUp && !btnDown) begin
            if (localSpeed_q < minSpd_q) begin
                localSpeed_q <= minSpd_q;
            end else if (localSpeed_q + BUTTON_STEP > maxSpd_q) begin
                localSpeed_q <= maxSpd_q;
            end else begin
                localSpeed_q <= localSpeed_q + BUTTON_STEP;
            end
        end else if (localMode && btnTick && btnDown && !btnUp) begin
            if (localSpeed_q < minSpd_q + BUTTON_STEP) begin
                localSpeed_q <= 12'h000;
            end else begin
                localSpeed_q <= localSpeed_q - BUTTON_STEP;
            end
        end
    end

    // store every change of the local speed
    logic [11:0] lastStored_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lastStored_q <= 12'h000;
            nvSpeedOut <= 12'h000;
            nvWrite <= 1'b0;
        end else begin
            nvWrite <= 1'b0;
            if (nvLoaded_q && localSpeed_q != lastStored_q) begin
                lastStored_q <= localSpeed_q;
                nvSpeedOut <= localSpeed_q;
                nvWrite <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remote reference scaling
    logic [11:0] refLevel, refLo, refSpan, refHi, mapped_speed, target;
    logic [23:0] product;
    logic belowLo;
    always_comb begin
        refLevel = reference_input_level;
        refLo = VOLT_LO;
        refSpan = VOLT_SPAN;
        refHi = VOLT_HI;
        case (refSel_q)
            MSR_SRC_VOLT: refLevel = reference_input_level;
            MSR_SRC_CURR: begin
                refLo = CURR_LO;
                refSpan = CURR_SPAN;
                refHi = CURR_HI;
            end
            MSR_SRC_PWM: begin
                refLevel = duty;
                refLo = DUTY_LO;
                refSpan = DUTY_SPAN;
                refHi = DUTY_HI;
            end
            default: refLevel = reference_input_level;
        endcase
    end
    assign belowLo = refLevel < refLo;
    assign product = (maxSpd_q > minSpd_q)
        ? 24'(maxSpd_q - minSpd_q) * 24'(((refLevel > refHi) ? refHi : refLevel) - refLo)
        : 24'h0;
    assign mapped_speed = minSpd_q + 12'(product / 24'(refSpan));

    // target speed before ramping
    always_comb begin
        if (localMode) begin
            target = (localSpeed_q < minSpd_q) ? 12'h000 : localSpeed_q;
        end else if (refSel_q == MSR_SRC_SERIAL) begin
            if (serRef_q < minSpd_q) begin
                target = frameLarge_q ? minSpd_q : 12'h000;
            end else begin
                target = serRef_q;
            end
        end else if (belowLo) begin
            target = frameLarge_q ? minSpd_q : 12'h000;
        end else begin
            target = mapped_speed;
        end
        if (target > maxSpd_q) begin
            target = maxSpd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // direction sequence and ramp
    logic wantCcw;
    assign wantCcw = frameLarge_q ? diDir : swDir;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= MSR_RUN;
            dirCcw <= 1'b0;
        end else begin
            case (state_q)
                MSR_RUN: begin
                    if (wantCcw != dirCcw) begin
                        state_q <= (speedNow_q == 12'h000) ? MSR_FLIP : MSR_DECEL;
                    end
                end
                MSR_DECEL: begin
                    if (speedNow_q == 12'h000) begin
                        state_q <= MSR_FLIP;
                    end
                end
                MSR_FLIP: begin
                    dirCcw <= wantCcw;
                    state_q <= MSR_ACCEL;
                end
                MSR_ACCEL: state_q <= MSR_RUN;
                default: state_q <= MSR_RUN;
            endcase
        end
    end

    // one rpm per ramp tick toward the target, zero during reversal
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            speedNow_q <= 12'h000;
        end else if (speedNow_q > maxSpd_q && rampTick) begin
            speedNow_q <= speedNow_q - 12'h001;
        end else if (rampTick) begin
            if (state_q == MSR_DECEL || state_q == MSR_FLIP) begin
                if (speedNow_q != 12'h000) begin
                    speedNow_q <= speedNow_q - 12'h001;
                end
            end else if (speedNow_q < target) begin
                speedNow_q <= speedNow_q + 12'h001;
            end else if (speedNow_q > target) begin
                speedNow_q <= speedNow_q - 12'h001;
            end
        end
    end

    // outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            speedCmd <= 12'h000;
            motorOn <= 1'b0;
        end else begin
            speedCmd <= speedNow_q;
            motorOn <= speedNow_q != 12'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence sqDirChange;
        state_q == MSR_RUN && wantCcw != dirCcw && speedNow_q != 12'h000;
    endsequence
    sequence sqDecel;
        state_q == MSR_DECEL;
    endsequence
    chk_reverse_decel: assert property (@(posedge clock) disable iff (rst)
        sqDirChange |=> sqDecel)
        else $error("direction change did not start deceleration");
    chk_dir_stable: assert property (@(posedge clock) disable iff (rst)
        state_q != MSR_FLIP |=> $stable(dirCcw))
        else $error("direction flipped outside flip state");
    chk_dir_source: assert property (@(posedge clock) disable iff (rst)
        state_q == MSR_FLIP |=> dirCcw == $past(frameLarge_q ? diDir : swDir))
        else $error("direction taken from wrong source");
    chk_local_hold: assert property (@(posedge clock) disable iff (rst)
        nvLoaded_q && !localMode && localSpeed_q <= maxSpd_q && !$changed(maxSpd_q) |=> $stable(localSpeed_q))
        else $error("local speed moved outside local mode");
    chk_button_step: assert property (@(posedge clock) disable iff (rst)
        nvLoaded_q && localMode && btnTick && btnUp && !btnDown && localSpeed_q >= minSpd_q
            && localSpeed_q + BUTTON_STEP <= maxSpd_q |=> localSpeed_q == $past(localSpeed_q) + BUTTON_STEP)
        else $error("button press did not raise speed");
    chk_local_off: assert property (@(posedge clock) disable iff (rst)
        localMode && localSpeed_q < minSpd_q |-> target == 12'h000)
        else $error("local speed below minimum not off");
    chk_max_limit: assert property (@(posedge clock) disable iff (rst)
        target <= maxSpd_q)
        else $error("target above maximum");
    chk_nv_store: assert property (@(posedge clock) disable iff (rst)
        nvLoaded_q && $changed(localSpeed_q) |=> nvWrite && nvSpeedOut == $past(localSpeed_q))
        else $error("local speed change not stored");
    chk_remote_off: assert property (@(posedge clock) disable iff (rst)
        !frameLarge_q && !localMode && refSel_q != MSR_SRC_SERIAL && belowLo |-> target == 12'h000)
        else $error("small frame below threshold not off");
    chk_large_min: assert property (@(posedge clock) disable iff (rst)
        frameLarge_q && refSel_q != MSR_SRC_SERIAL && belowLo && minSpd_q <= maxSpd_q |-> target == minSpd_q)
        else $error("large frame below threshold not at minimum");
    chk_max_decel: assert property (@(posedge clock) disable iff (rst)
        speedNow_q > maxSpd_q && rampTick |=> speedNow_q == $past(speedNow_q) - 12'h001)
        else $error("no deceleration to new maximum");
    chk_clamp_top: assert property (@(posedge clock) disable iff (rst)
        !localMode && refSel_q != MSR_SRC_SERIAL && refLevel >= refHi && maxSpd_q >= minSpd_q
            |-> mapped_speed == maxSpd_q)
        else $error("reference above range not clamped");
endmodule

// *** verification/msr_operator_model.sv ***
// Purpose: operator side pulse-width speed reference source
// Assumes: input period scaled down to PERIOD clock cycles
// Notes: highCycles of zero keeps the line low with no edges
module msr_operator_model #(
    parameter int PERIOD = 100
) (
    input wire logic clock,
    input wire logic [7:0] highCycles,
    output logic pwmOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int phase = 0;
    initial pwmOut = 1'b0;
    // fixed period, high for the first highCycles cycles of it
    always @(posedge clock) begin
        phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
        pwmOut <= (phase < int'(highCycles));
    end
endmodule

// *** verification/motor_speed_reference_select_test.sv ***
// Purpose: self-checking bench for the speed reference selector
// Assumes: short ramp, button and duty timeout counts
// Notes: remote cases in a table, direction and local cases by hand
module motor_speed_reference_select_test
    import msr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] c; logic [11:0] l; logic [7:0] h; logic [11:0] s;} msr_row_t;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, pwm;
    logic [7:0] paddr = '0, pwmHigh = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, nvWrite, dirCcw, motorOn;
    logic dirSw = 0, localSel = 0, dirIn = 0, btnUp = 0, btnDown = 0;
    logic [11:0] level = '0, nvIn = 12'h12C, nvSpeedOut, speedCmd;
    int n_errors = 0, num_checks = 0, nvWrites = 0;
    // control word, level, pulse high cycles, settled speed
    msr_row_t rows [11] = '{
        '{3'h2, 12'h258, 8'h00, 12'h352}, '{3'h2, 12'h064, 8'h00, 12'h000},
        '{3'h2, 12'h4B0, 8'h00, 12'h5DC}, '{3'h4, 12'h4B0, 8'h00, 12'h352},
        '{3'h4, 12'h12C, 8'h00, 12'h000}, '{3'h0, 12'h000, 8'h32, 12'h32B},
        '{3'h0, 12'h000, 8'h05, 12'h000}, '{3'h0, 12'h000, 8'h61, 12'h5DC},
        '{3'h3, 12'h064, 8'h61, 12'h0C8}, '{3'h7, 12'h064, 8'h61, 12'h3E8},
        '{3'h5, 12'h4B0, 8'h61, 12'h352}};

    // 25 MHz system clock
    always #20 clock = ~clock;

    // count store pulses towards the nv memory
    always @(posedge clock) begin
        if (nvWrite === 1'b1) nvWrites <= nvWrites + 1;
    end

    msr_operator_model i_msr_operator_model (.clock(clock), .highCycles(pwmHigh), .pwmOut(pwm));

    msr_speed_ref #(.RAMP_CYC(4), .BUTTON_CYC(8), .TIMEOUT_CYC(200)) i_msr_speed_ref (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dirSwitchIn(dirSw), .localSelIn(localSel), .direction_select_input(dirIn),
        .pulse_width_reference_input(pwm), .buttonUpIn(btnUp), .buttonDownIn(btnDown),
        .reference_input_level(level), .nvSpeedIn(nvIn), .nvSpeedOut(nvSpeedOut),
        .nvWrite(nvWrite), .speedCmd(speedCmd), .dirCcw(dirCcw), .motorOn(motorOn));

    ////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("BAD %0t no pready", $time);
            n_errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for speed (sel 0) or direction (sel 1)
    task automatic waitOut(input logic sel, input logic [11:0] v);
        int n;
        n = 0;
        while ((sel ? dirCcw !== v[0] : speedCmd !== v) && n < 9000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 9000) begin
            $display("BAD %0t output never reached %h", $time, v);
            n_errors++;
            report_and_stop();
        end
    endtask

    // reach the speed, then it must stay there
    task automatic settle(input logic [11:0] s);
        waitOut(1'b0, s);
        repeat (20) @(posedge clock);
        chk({20'h0, speedCmd}, {20'h0, s});
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, REG_MAXSPD, 32'h0);
        chk(rd, 32'h5DC);
        apb(1'b0, REG_MINSPD, 32'h0);
        chk(rd, 32'h0C8);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, REG_STATUS, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, REG_SERREF, 32'h3E8);
        foreach (rows[i]) begin
            apb(1'b1, REG_CTRL, {29'h0, rows[i].c});
            level <= rows[i].l;
            pwmHigh <= rows[i].h;
            settle(rows[i].s);
            chk({31'h0, motorOn}, {31'h0, rows[i].s != 12'h0});
            if (i == 5) begin
                apb(1'b0, REG_DUTY, 32'h0);
                chk(rd, 32'h11F4);
            end
            $display("row %0d done", i);
        end
        dirIn <= 1'b1;
        waitOut(1'b1, 12'h001);
        chk(32'(speedCmd < 12'h002), 32'h1);
        settle(12'h352);
        apb(1'b1, REG_CTRL, 32'h2);
        waitOut(1'b1, 12'h000);
        chk(32'(speedCmd < 12'h002), 32'h1);
        settle(12'h5DC);
        $display("direction done");
        localSel <= 1'b1;
        settle(12'h12C);
        btnUp <= 1'b1;
        settle(12'h5DC);
        chk({20'h0, nvSpeedOut}, 32'h5DC);
        btnUp <= 1'b0;
        apb(1'b1, REG_MAXSPD, 32'h3E8);
        settle(12'h3E8);
        btnDown <= 1'b1;
        settle(12'h000);
        chk({31'h0, motorOn}, 32'h0);
        btnDown <= 1'b0;
        chk(32'(nvWrites), 32'h0000_00CB);
        $display("local done");
        nvIn <= 12'h1F4;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        chk({18'h0, nvWrite, motorOn, speedCmd}, 32'h0);
        rst <= 1'b0;
        settle(12'h1F4);
        chk({20'h0, nvSpeedOut}, 32'h1F4);
        $display("reset done");
        report_and_stop();
    end
endmodule
